// ==== cprs_defs.vh ====
// Constants shared by the control port redirect and soft reset block
`ifndef CPRS_DEFS_VH
`define CPRS_DEFS_VH

// ****************************************
// Register offsets
// ****************************************
`define CPRS_REG_SYS_CTRL_ONE 8'h03
`define CPRS_REG_IF_CTRL      8'h06
`define CPRS_REG_STATUS       8'h07
`define CPRS_REG_KEY          8'h08

// ****************************************
// Field positions
// ****************************************
`define CPRS_BIT_SW_RESET     14
`define CPRS_HOLD_MSB         11
`define CPRS_HOLD_LSB         10
`define CPRS_BIT_SEC_SEL      15
`define CPRS_ADDR_MSB         14
`define CPRS_ADDR_LSB         13
`define CPRS_STS_RST_BIT      0
`define CPRS_STS_CONF_MSB     2
`define CPRS_STS_CONF_LSB     1
`define CPRS_KEY_OPEN_BIT     0

// ****************************************
// Reset values and codes
// ****************************************
`define CPRS_HOLD_RST         2'h3
`define CPRS_SEC_SEL_RST      1'h1
`define CPRS_ADDR_SEL_RST     2'h0
`define CPRS_CONF_RST         2'h0
`define CPRS_CONF_DEV         2'h0
`define CPRS_KEY_VALUE        16'h5AC3
`define CPRS_SYNC_RST         6'h0F

// ****************************************
// Bus addresses (7-bit)
// ****************************************
`define CPRS_PRIMARY_ADDR_SELECT_00      7'h34
`define CPRS_PRIMARY_ADDR_SELECT_01      7'h36
`define CPRS_PRIMARY_ADDR_SELECT_10      7'h3C
`define CPRS_PRIMARY_ADDR_SELECT_11      7'h3E

// ****************************************
// Power states seen from outside
// ****************************************
`define CPRS_PWR_OFF          2'h0
`define CPRS_PWR_PRE_ACTIVE   2'h1
`define CPRS_PWR_ACTIVE       2'h2
`define CPRS_PWR_HIBERNATE    2'h3

// ****************************************
// Timing
// ****************************************
`define CPRS_CLK_PERIOD_NS    8
`define CPRS_HOLD_BASE_NS     15000000
`define CPRS_BYTE_LAST        3'h7

`endif

// ==== cprs_sync.v ====
// Two flip-flop synchroniser for a vector of asynchronous pin levels
`timescale 1ns/1ps
module cprs_sync
#(
    parameter       W       = 6,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
)
(
    input  wire         clk,
    input  wire         rst,
    input  wire [W-1:0] din,
    output wire [W-1:0] dout
);

    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // First stage feeds only the second stage
    always @(posedge clk)
    begin
        if (rst)
        begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end
        else
        begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;

endmodule

// ==== cprs_rst_timer.v ====
// Timed low pulse for the host and memory reset lines
`timescale 1ns/1ps
module cprs_rst_timer
#(
    parameter CW       = 24,
    parameter BASE_CYC = 1875000
)
(
    input  wire       clk,
    input  wire       rst,
    input  wire       start,
    input  wire [1:0] sel,
    output wire       rst_n
);

    reg  [CW-1:0] cnt_q;
    reg           rst_n_q;
    wire [31:0]   span_w;
    wire [31:0]   load_w;

    // Each step of the hold code doubles the base time
    assign span_w = BASE_CYC << sel;
    assign load_w = span_w - 32'h1;

    // A new start restarts the full hold even mid-pulse
    always @(posedge clk)
    begin
        if (rst)
        begin
            cnt_q   <= {CW{1'b0}};
            rst_n_q <= 1'b1;
        end
        else if (start)
        begin
            cnt_q   <= load_w[CW-1:0];
            rst_n_q <= 1'b0;
        end
        else if (!rst_n_q)
        begin
            if (cnt_q == {CW{1'b0}})
                rst_n_q <= 1'b1;
            else
                cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
        end
    end

    assign rst_n = rst_n_q;

endmodule

// ==== cprs_top.v ====
// Two-wire control port with pin redirection, address select and soft reset
`timescale 1ns/1ps
`include "cprs_defs.vh"

module cprs_top
#(
    parameter HOLD_BASE_CYC = (`CPRS_HOLD_BASE_NS + `CPRS_CLK_PERIOD_NS - 1) / `CPRS_CLK_PERIOD_NS,
    parameter HOLD_CW       = 24
)
(
    input  wire       CORE_CLK,
    input  wire       RST,
    input  wire [1:0] PWR_STATE,
    input  wire       CONFIG_MODE_PIN_HIGH,
    input  wire       CONFIG_MODE_PIN_LOW,
    input  wire       PRIMARY_SCL,
    input  wire       PRIMARY_SDA_I,
    output wire       PRIMARY_SDA_O,
    output wire       PRIMARY_SDA_OE_N,
    input  wire       SECONDARY_CLOCK_PIN_I,
    input  wire       SECONDARY_DATA_PIN_I,
    output wire       SECONDARY_DATA_PIN_O,
    output wire       SECONDARY_DATA_PIN_OE_N,
    output wire       HOST_RESET_N_O,
    output wire       HOST_RESET_N_OE_N,
    output wire       MEMORY_RESET_N,
    output wire       DEVELOPMENT_MODE,
    output wire       SECONDARY_ACTIVE
);

    // ****************************************
    // Declarations
    // ****************************************
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_RX   = 3'h1;
    localparam [2:0] S_ACK  = 3'h2;
    localparam [2:0] S_TX   = 3'h3;
    localparam [2:0] S_MACK = 3'h4;
    localparam [2:0] S_TXW  = 3'h5;

    localparam [1:0] K_ADDR = 2'h0;
    localparam [1:0] K_REG  = 2'h1;
    localparam [1:0] K_HI   = 2'h2;
    localparam [1:0] K_LO   = 2'h3;

    wire [5:0]  pins_s;
    wire        pri_scl_s;
    wire        pri_sda_s;
    wire        sec_scl_s;
    wire        sec_sda_s;
    wire [1:0]  conf_s;
    wire        dev_mode_w;
    wire        route_sec_w;
    wire        scl_w;
    wire        sda_w;
    wire [6:0]  primary_addr_select_w;
    wire        scl_rise_w;
    wire        scl_fall_w;
    wire        start_w;
    wire        stop_w;
    wire        sw_start_w;
    wire        host_rst_n;
    wire [7:0]  rx_byte_w;
    wire [1:0]  kind_next_w;

    reg  [1:0]  conf_q;
    reg         scl_prev_q;
    reg         sda_prev_q;
    reg  [2:0]  st_q;
    reg  [1:0]  kind_q;
    reg  [2:0]  cnt_q;
    reg  [7:0]  sh_q;
    reg  [7:0]  tx_sh_q;
    reg         tx_hi_q;
    reg         rw_q;
    reg         drive_q;
    reg  [7:0]  reg_q;
    reg  [7:0]  hi_q;
    reg         wr_stb_q;
    reg  [15:0] wr_data_q;
    reg         wr_sec_q;
    reg  [1:0]  hold_q;
    reg         sec_sel_q;
    reg  [1:0]  addr_sel_q;
    reg         unlocked_q;
    reg  [15:0] rd_word;

    // Primary port address chosen by the two-bit select code
    function [6:0] addr_lookup;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    addr_lookup = `CPRS_PRIMARY_ADDR_SELECT_00;
                2'h1:    addr_lookup = `CPRS_PRIMARY_ADDR_SELECT_01;
                2'h2:    addr_lookup = `CPRS_PRIMARY_ADDR_SELECT_10;
                default: addr_lookup = `CPRS_PRIMARY_ADDR_SELECT_11;
            endcase
        end
    endfunction

    // ****************************************
    // Pin synchronisers
    // ****************************************
    // Bus lines idle high, mode pins reset to the development code
    cprs_sync
    #(
        .W       (6),
        .RST_VAL (`CPRS_SYNC_RST)
    )
    u_sync
    (
        .clk  (CORE_CLK),
        .rst  (RST),
        .din  ({CONFIG_MODE_PIN_HIGH, CONFIG_MODE_PIN_LOW, SECONDARY_DATA_PIN_I,
                SECONDARY_CLOCK_PIN_I, PRIMARY_SDA_I, PRIMARY_SCL}),
        .dout (pins_s)
    );

    assign pri_scl_s = pins_s[0];
    assign pri_sda_s = pins_s[1];
    assign sec_scl_s = pins_s[2];
    assign sec_sda_s = pins_s[3];
    assign conf_s    = pins_s[5:4];

    // ****************************************
    // Mode capture
    // ****************************************
    // Tracks the pins while OFF and freezes on the way out, so a stray
    // change during operation cannot move the port under a live host
    always @(posedge CORE_CLK)
    begin
        if (RST)
            conf_q <= `CPRS_CONF_RST;
        else if (PWR_STATE == `CPRS_PWR_OFF)
            conf_q <= conf_s;
    end

    assign dev_mode_w = (conf_q == `CPRS_CONF_DEV);

    // ****************************************
    // Port routing and address
    // ****************************************
    // The engine runs in every power state, so OFF and PRE-ACTIVE work too
    assign route_sec_w = dev_mode_w & sec_sel_q;
    assign scl_w       = route_sec_w ? sec_scl_s : pri_scl_s;
    assign sda_w       = route_sec_w ? sec_sda_s : pri_sda_s;

    // Custom modes ignore the select code and keep the fixed address
    assign primary_addr_select_w = (route_sec_w || !dev_mode_w) ? `CPRS_PRIMARY_ADDR_SELECT_00
                                                     : addr_lookup(addr_sel_q);

    // Line edges and bus conditions
    assign scl_rise_w  = scl_w & ~scl_prev_q;
    assign scl_fall_w  = ~scl_w & scl_prev_q;
    assign start_w     = scl_w & scl_prev_q & sda_prev_q & ~sda_w;
    assign stop_w      = scl_w & scl_prev_q & ~sda_prev_q & sda_w;
    assign rx_byte_w   = {sh_q[6:0], sda_w};
    assign kind_next_w = (kind_q == K_LO) ? K_HI : kind_q + 2'h1;

    always @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end
        else
        begin
            scl_prev_q <= scl_w;
            sda_prev_q <= sda_w;
        end
    end

    // ****************************************
    // Serial engine
    // ****************************************
    // While the data line is held low for an acknowledge, start and stop
    // are not looked at: only clock falls may release it
    always @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            st_q      <= S_IDLE;
            kind_q    <= K_ADDR;
            cnt_q     <= 3'h0;
            sh_q      <= 8'h00;
            tx_sh_q   <= 8'h00;
            tx_hi_q   <= 1'b1;
            rw_q      <= 1'b0;
            drive_q   <= 1'b0;
            reg_q     <= 8'h00;
            hi_q      <= 8'h00;
            wr_stb_q  <= 1'b0;
            wr_data_q <= 16'h0000;
            wr_sec_q  <= 1'b0;
        end
        else
        begin
            wr_stb_q <= 1'b0;
            if (start_w && !drive_q)
            begin
                st_q   <= S_RX;
                kind_q <= K_ADDR;
                cnt_q  <= 3'h0;
            end
            else if (stop_w && !drive_q)
                st_q <= S_IDLE;
            else
            begin
                case (st_q)
                    S_RX:
                    begin
                        if (scl_rise_w)
                        begin
                            sh_q  <= rx_byte_w;
                            cnt_q <= cnt_q + 3'h1;
                            if (cnt_q == `CPRS_BYTE_LAST)
                            begin
                                st_q <= S_ACK;
                                case (kind_q)
                                    K_ADDR:
                                    begin
                                        rw_q    <= sda_w;
                                        tx_hi_q <= 1'b1;
                                        if (sh_q[6:0] != primary_addr_select_w)
                                            st_q <= S_IDLE;
                                    end
                                    K_REG:   reg_q <= rx_byte_w;
                                    K_HI:    hi_q  <= rx_byte_w;
                                    default:
                                    begin
                                        // Acts before the acknowledge clock
                                        wr_stb_q  <= 1'b1;
                                        wr_data_q <= {hi_q, rx_byte_w};
                                        wr_sec_q  <= route_sec_w;
                                    end
                                endcase
                            end
                        end
                    end
                    S_ACK:
                    begin
                        if (scl_fall_w)
                        begin
                            if (!drive_q)
                                drive_q <= 1'b1;
                            else if (kind_q == K_ADDR && rw_q)
                            begin
                                st_q    <= S_TX;
                                tx_sh_q <= rd_word[15:8];
                                drive_q <= ~rd_word[15];
                                tx_hi_q <= 1'b0;
                                cnt_q   <= 3'h0;
                            end
                            else
                            begin
                                drive_q <= 1'b0;
                                st_q    <= S_RX;
                                kind_q  <= kind_next_w;
                                cnt_q   <= 3'h0;
                            end
                        end
                    end
                    S_TX:
                    begin
                        if (scl_fall_w)
                        begin
                            if (cnt_q == `CPRS_BYTE_LAST)
                            begin
                                drive_q <= 1'b0;
                                st_q    <= S_MACK;
                            end
                            else
                            begin
                                cnt_q   <= cnt_q + 3'h1;
                                tx_sh_q <= {tx_sh_q[6:0], 1'b0};
                                drive_q <= ~tx_sh_q[6];
                            end
                        end
                    end
                    S_MACK:
                    begin
                        // A missing acknowledge ends the read
                        if (scl_rise_w)
                            st_q <= sda_w ? S_IDLE : S_TXW;
                    end
                    S_TXW:
                    begin
                        if (scl_fall_w)
                        begin
                            st_q    <= S_TX;
                            tx_sh_q <= tx_hi_q ? rd_word[15:8] : rd_word[7:0];
                            drive_q <= tx_hi_q ? ~rd_word[15] : ~rd_word[7];
                            tx_hi_q <= ~tx_hi_q;
                            cnt_q   <= 3'h0;
                        end
                    end
                    default: st_q <= S_IDLE;
                endcase
            end
        end
    end

    // ****************************************
    // Register file
    // ****************************************
    // Reset command needs an open key; a wrong key value closes it again
    assign sw_start_w = wr_stb_q && (reg_q == `CPRS_REG_SYS_CTRL_ONE)
                        && wr_data_q[`CPRS_BIT_SW_RESET] && unlocked_q;

    always @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            hold_q     <= `CPRS_HOLD_RST;
            sec_sel_q  <= `CPRS_SEC_SEL_RST;
            addr_sel_q <= `CPRS_ADDR_SEL_RST;
            unlocked_q <= 1'b0;
        end
        else if (wr_stb_q)
        begin
            case (reg_q)
                `CPRS_REG_SYS_CTRL_ONE:
                    hold_q <= wr_data_q[`CPRS_HOLD_MSB:`CPRS_HOLD_LSB];
                `CPRS_REG_IF_CTRL:
                begin
                    sec_sel_q <= wr_data_q[`CPRS_BIT_SEC_SEL];
                    if (wr_sec_q && dev_mode_w)
                        addr_sel_q <= wr_data_q[`CPRS_ADDR_MSB:`CPRS_ADDR_LSB];
                end
                `CPRS_REG_KEY:
                    unlocked_q <= (wr_data_q == `CPRS_KEY_VALUE);
                default:
                    unlocked_q <= unlocked_q;
            endcase
        end
    end

    // Read view; the reset command bit is never stored and reads 0
    always @*
    begin
        rd_word = 16'h0000;
        case (reg_q)
            `CPRS_REG_SYS_CTRL_ONE:
                rd_word[`CPRS_HOLD_MSB:`CPRS_HOLD_LSB] = hold_q;
            `CPRS_REG_IF_CTRL:
            begin
                rd_word[`CPRS_BIT_SEC_SEL]               = sec_sel_q;
                rd_word[`CPRS_ADDR_MSB:`CPRS_ADDR_LSB]   = addr_sel_q;
            end
            `CPRS_REG_STATUS:
            begin
                rd_word[`CPRS_STS_RST_BIT]                   = ~host_rst_n;
                rd_word[`CPRS_STS_CONF_MSB:`CPRS_STS_CONF_LSB] = conf_q;
            end
            `CPRS_REG_KEY:
                rd_word[`CPRS_KEY_OPEN_BIT] = unlocked_q;
            default:
                rd_word = 16'h0000;
        endcase
    end

    // ****************************************
    // Reset pulse
    // ****************************************
    cprs_rst_timer
    #(
        .CW       (HOLD_CW),
        .BASE_CYC (HOLD_BASE_CYC)
    )
    u_timer
    (
        .clk   (CORE_CLK),
        .rst   (RST),
        .start (sw_start_w),
        .sel   (sw_start_w ? wr_data_q[`CPRS_HOLD_MSB:`CPRS_HOLD_LSB] : hold_q),
        .rst_n (host_rst_n)
    );

    // ****************************************
    // Outputs
    // ****************************************
    // Open-drain: data is always low, the enable decides
    assign HOST_RESET_N_O          = 1'b0;
    assign HOST_RESET_N_OE_N       = host_rst_n;
    assign MEMORY_RESET_N          = host_rst_n;
    assign PRIMARY_SDA_O           = 1'b0;
    assign PRIMARY_SDA_OE_N        = ~(drive_q & ~route_sec_w);
    assign SECONDARY_DATA_PIN_O    = 1'b0;
    assign SECONDARY_DATA_PIN_OE_N = ~(drive_q & route_sec_w);
    assign DEVELOPMENT_MODE        = dev_mode_w;
    assign SECONDARY_ACTIVE        = route_sec_w;

endmodule

// ==== cprs_top_sva.sv ====
// Checker for the control port redirect and soft reset block
`timescale 1ns/1ps
`include "cprs_defs.vh"
module cprs_top_sva
#(
    parameter HOLD_BASE_CYC = 20
)
(
    input wire       CORE_CLK,
    input wire       RST,
    input wire [1:0] PWR_STATE,
    input wire       SECONDARY_CLOCK_PIN_I,
    input wire       PRIMARY_SDA_O,
    input wire       PRIMARY_SDA_OE_N,
    input wire       SECONDARY_DATA_PIN_O,
    input wire       SECONDARY_DATA_PIN_OE_N,
    input wire       HOST_RESET_N_O,
    input wire       HOST_RESET_N_OE_N,
    input wire       MEMORY_RESET_N,
    input wire       DEVELOPMENT_MODE,
    input wire       SECONDARY_ACTIVE
);
    localparam int B = HOLD_BASE_CYC;
    reg [15:0] low_q;
    // Length of the running reset pulse, cleared while the line is released
    always @(posedge CORE_CLK)
    begin
        if (RST || HOST_RESET_N_OE_N)
            low_q <= 16'h0000;
        else
            low_q <= low_q + 16'h0001;
    end
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    // Six idle clock-low cycles only happen when the host has stalled
    sequence s_held;
        (!SECONDARY_DATA_PIN_OE_N && !SECONDARY_CLOCK_PIN_I) [*6];
    endsequence
    property p_rst_idle;
        disable iff (1'b0) RST |=> PRIMARY_SDA_OE_N && SECONDARY_DATA_PIN_OE_N
            && HOST_RESET_N_OE_N && SECONDARY_ACTIVE && DEVELOPMENT_MODE;
    endproperty
    property p_route;
        SECONDARY_ACTIVE |-> PRIMARY_SDA_OE_N;
    endproperty
    property p_sec_gate;
        !SECONDARY_ACTIVE |-> SECONDARY_DATA_PIN_OE_N;
    endproperty
    property p_custom;
        !DEVELOPMENT_MODE |-> !SECONDARY_ACTIVE;
    endproperty
    property p_odrain;
        !HOST_RESET_N_O && !PRIMARY_SDA_O && !SECONDARY_DATA_PIN_O;
    endproperty
    property p_mem;
        MEMORY_RESET_N == HOST_RESET_N_OE_N;
    endproperty
    property p_rst_len;
        $rose(HOST_RESET_N_OE_N) && !$past(RST) |->
            low_q == B || low_q == 2 * B || low_q == 4 * B || low_q == 8 * B;
    endproperty
    property p_frozen;
        PWR_STATE != `CPRS_PWR_OFF && $past(PWR_STATE) != `CPRS_PWR_OFF && !$past(RST)
            |-> $stable(DEVELOPMENT_MODE);
    endproperty
    property p_held;
        s_held |=> !SECONDARY_DATA_PIN_OE_N;
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle after reset");
    a_route: assert property (p_route) else $error("primary driven while redirected");
    a_sec_gate: assert property (p_sec_gate) else $error("secondary driven while off");
    a_custom: assert property (p_custom) else $error("secondary port in custom mode");
    a_odrain: assert property (p_odrain) else $error("open drain level not low");
    a_mem: assert property (p_mem) else $error("memory reset differs from host reset");
    a_rst_len: assert property (p_rst_len) else $error("reset pulse length wrong");
    a_frozen: assert property (p_frozen) else $error("mode changed outside off state");
    a_held: assert property (p_held) else $error("acknowledge dropped without clock");
endmodule
bind cprs_top cprs_top_sva #(.HOLD_BASE_CYC(HOLD_BASE_CYC)) u_sva
(
    .CORE_CLK(CORE_CLK), .RST(RST), .PWR_STATE(PWR_STATE),
    .SECONDARY_CLOCK_PIN_I(SECONDARY_CLOCK_PIN_I), .PRIMARY_SDA_O(PRIMARY_SDA_O),
    .PRIMARY_SDA_OE_N(PRIMARY_SDA_OE_N), .SECONDARY_DATA_PIN_O(SECONDARY_DATA_PIN_O),
    .SECONDARY_DATA_PIN_OE_N(SECONDARY_DATA_PIN_OE_N), .HOST_RESET_N_O(HOST_RESET_N_O),
    .HOST_RESET_N_OE_N(HOST_RESET_N_OE_N), .MEMORY_RESET_N(MEMORY_RESET_N),
    .DEVELOPMENT_MODE(DEVELOPMENT_MODE), .SECONDARY_ACTIVE(SECONDARY_ACTIVE)
);

// ==== cprs_host.sv ====
// Two-wire bus host model for whichever control port the bench selects
`timescale 1ns/1ps
module cprs_host
(
    input  wire clk,
    input  wire sda,
    output reg  scl,
    output reg  sdo
);
    // Idle bus: clock stands high, data left to the pull-up
    initial
    begin
        scl = 1'b1;
        sdo = 1'b1;
    end
    // One step; data moves a cycle after the clock so no false start or stop
    task st(input c, input d, output x);
    begin
        repeat (3) @(posedge clk);
        @(negedge clk) x = sda;
        @(posedge clk);
        scl <= c;
        @(posedge clk);
        sdo <= d;
    end
    endtask
    task start;
        reg x;
    begin
        st(1'b0, 1'b1, x);
        st(1'b1, 1'b1, x);
        st(1'b1, 1'b0, x);
    end
    endtask
    task stop;
        reg x;
    begin
        st(1'b0, 1'b0, x);
        st(1'b1, 1'b0, x);
        st(1'b1, 1'b1, x);
    end
    endtask
    // Nine bits MSB first, line read in the middle of each high phase
    task xb(input [8:0] w, output [8:0] r);
        integer i;
        reg     x;
    begin
        for (i = 8; i >= 0; i = i - 1)
        begin
            st(1'b0, w[i], x);
            st(1'b1, w[i], x);
            st(1'b1, w[i], x);
            r[i] = x;
        end
    end
    endtask
endmodule

// ==== cprs_top_bench.sv ====
// Self-checking bench for the control port redirect and soft reset block
`timescale 1ns/1ps
`include "cprs_defs.vh"
`define CHK(a, e) begin n_compared = n_compared + 1; if ((a) !== (e)) begin \
    n_mismatch = n_mismatch + 1; $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module cprs_top_bench;
    reg        clk, rst, p, chi, clo, ak, x;
    reg [1:0]  pw;
    reg [15:0] lc, l0, v;
    reg [8:0]  r;
    integer    seed, n_mismatch, n_compared, c, i;
    wire       hscl, hsdo, pso, psn, sso, ssn, hro, hrn, mrn, dev, sac;
    wire       psda = psn & (p | hsdo);
    wire       ssda = ssn & (~p | hsdo);
    cprs_top #(.HOLD_BASE_CYC(20)) i_dut
    (
        .CORE_CLK(clk), .RST(rst), .PWR_STATE(pw),
        .CONFIG_MODE_PIN_HIGH(chi), .CONFIG_MODE_PIN_LOW(clo),
        .PRIMARY_SCL(p | hscl), .PRIMARY_SDA_I(psda), .PRIMARY_SDA_O(pso),
        .PRIMARY_SDA_OE_N(psn), .SECONDARY_CLOCK_PIN_I(~p | hscl),
        .SECONDARY_DATA_PIN_I(ssda), .SECONDARY_DATA_PIN_O(sso),
        .SECONDARY_DATA_PIN_OE_N(ssn), .HOST_RESET_N_O(hro), .HOST_RESET_N_OE_N(hrn),
        .MEMORY_RESET_N(mrn), .DEVELOPMENT_MODE(dev), .SECONDARY_ACTIVE(sac)
    );
    cprs_host h (.clk(clk), .sda(p ? ssda : psda), .scl(hscl), .sdo(hsdo));
    function [6:0] adr(input [1:0] s);
        adr = (s == 2'h0) ? 7'h34 : (s == 2'h1) ? 7'h36 : (s == 2'h2) ? 7'h3C : 7'h3E;
    endfunction
    function [15:0] hold(input [1:0] s);
        hold = 16'h0014 << s;
    endfunction
    task wr(input [6:0] a, input [7:0] g, input [15:0] d);
    begin
        h.start;
        h.xb({a, 2'b01}, r);
        ak = r[0];
        h.xb({g, 1'b1}, r);
        h.xb({d[15:8], 1'b1}, r);
        h.xb({d[7:0], 1'b1}, r);
        h.stop;
    end
    endtask
    task rd(input [7:0] g);
    begin
        h.start;
        h.xb({7'h34, 2'b01}, r);
        h.xb({g, 1'b1}, r);
        h.start;
        h.xb({7'h34, 2'b11}, r);
        h.xb(9'h1FE, r);
        v[15:8] = r[8:1];
        h.xb(9'h1FF, r);
        v[7:0] = r[8:1];
        h.stop;
    end
    endtask
    task tally_and_finish;
    begin
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask
    // ****************************************
    // Clock, low-time counter and watchdog
    // ****************************************
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Counts every cycle the host reset is held low
    always @(posedge clk)
        lc <= rst ? 16'h0000 : lc + {15'h0000, ~hrn};
    initial
    begin
        repeat (90000) @(posedge clk);
        n_mismatch = n_mismatch + 1;
        tally_and_finish;
    end
    // Main sequence
    initial
    begin
        rst = 1'b1; p = 1'b1; pw = 2'h0; chi = 1'b0; clo = 1'b0;
        seed = 32'hE8BE; n_mismatch = 0; n_compared = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        c = $random(seed);
        pw <= {1'b0, c[0]};
        repeat (6) @(posedge clk);
        `CHK({dev, sac, mrn, hrn}, 4'hF)
        rd(8'h06);
        `CHK(v[15:13], 3'h4)
        rd(8'h03);
        `CHK(v[11:10], 2'h3)
        p <= 1'b0;
        wr(7'h34, 8'h06, 16'h8000);
        `CHK(ak, 1'b1)
        p <= 1'b1;
        wr(7'h34, 8'h08, 16'h0000);
        l0 = lc;
        c = $random(seed);
        wr(7'h34, 8'h03, c[15:0] | 16'h4000);
        repeat (40) @(posedge clk);
        `CHK(lc - l0, 16'h0000)
        wr(7'h34, 8'h08, 16'h5AC3);
        for (c = 0; c < 4; c = c + 1)
        begin
            l0 = lc;
            wr(7'h34, 8'h03, {4'h4, c[1:0], 10'h000});
            for (i = 0; i < 400 && hrn !== 1'b1; i = i + 1) @(posedge clk);
            `CHK(lc - l0, hold(c))
            rd(8'h03);
            `CHK({v[14], v[11:10]}, {1'b0, c[1:0]})
        end
        $display("test soft reset done");
        h.start;
        h.xb({7'h34, 2'b01}, r);
        h.xb(9'h007, r);
        h.xb(9'h081, r);
        for (i = 7; i >= 0; i = i - 1)
        begin
            h.st(1'b0, 1'b0, x);
            h.st(1'b1, 1'b0, x);
        end
        h.st(1'b0, 1'b1, x);
        repeat (4) @(posedge clk);
        `CHK(hrn, 1'b0)
        repeat (60) @(posedge clk);
        `CHK(ssda, 1'b0)
        h.st(1'b1, 1'b1, x);
        h.st(1'b0, 1'b1, x);
        h.st(1'b0, 1'b1, x);
        `CHK(ssda, 1'b1)
        h.stop;
        $display("test stalled acknowledge done");
        for (c = 0; c < 4; c = c + 1)
        begin
            p <= 1'b1;
            wr(7'h34, 8'h06, {1'b1, c[1:0], 13'h0000});
            wr(7'h34, 8'h06, {1'b0, c[1:0], 13'h0000});
            `CHK(sac, 1'b0)
            p <= 1'b0;
            wr(adr(c + 1), 8'h06, 16'h0000);
            `CHK(ak, 1'b1)
            wr(adr(c), 8'h06, {1'b1, ~c[1:0], 13'h0000});
            `CHK({ak, sac}, 2'h1)
            p <= 1'b1;
            rd(8'h06);
            `CHK(v[15:13], {1'b1, c[1:0]})
        end
        wr(7'h3E, 8'h06, 16'h8000);
        `CHK(ak, 1'b1)
        $display("test address select done");
        pw <= `CPRS_PWR_OFF;
        c = $random(seed);
        if (c[1:0] == 2'h0)
            c = 3;
        {chi, clo} <= c[1:0];
        repeat (8) @(posedge clk);
        `CHK({dev, sac}, 2'h0)
        p <= 1'b0;
        wr(7'h34, 8'h06, 16'hE000);
        `CHK({ak, sac}, 2'h0)
        pw <= `CPRS_PWR_ACTIVE;
        repeat (4) @(posedge clk);
        pw <= `CPRS_PWR_OFF;
        {chi, clo} <= 2'h0;
        repeat (8) @(posedge clk);
        `CHK(dev, 1'b1)
        $display("test custom mode done");
        tally_and_finish;
    end
endmodule
